// file: logic/kwi_top.sv
// module: keyboard wake interrupt block with APB register slave
`timescale 1ns/10ps
module kwi_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [kwi_pkg::KWI_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [kwi_pkg::KWI_PINS-1:0] key_wake_input,
   input wire logic [kwi_pkg::KWI_PINS-1:0] port_dir_out,
   input wire logic vector_fetch,
   input wire logic break_active,
   output logic [kwi_pkg::KWI_PINS-1:0] pin_dir_out,
   output logic [kwi_pkg::KWI_PINS-1:0] pull_up_en,
   output logic [kwi_pkg::KWI_PINS-1:0] pull_down_en,
   output logic irq_request,
   output logic wake_request
);
   import kwi_pkg::*;

   // ------------------------------------------------------------------
   // synchronised pin levels
   // ------------------------------------------------------------------
   kwi_sync_if sif ();
   assign sif.raw = key_wake_input;

   kwi_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .port(sif.sync)
   );

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [4:0] enable_reg, enable_next;
   logic [4:0] polarity_reg, polarity_next;
   logic mask_reg, mask_next;
   logic sense_reg, sense_next;
   logic allow_reg, allow_next;
   logic latch_reg, latch_next;
   logic ack_pend_reg, ack_pend_next;
   logic [4:0] prev_reg, prev_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;
   logic wake_reg, wake_next;
   logic [4:0] dir_reg, dir_next;
   logic [4:0] pu_reg, pu_next;
   logic [4:0] pd_reg, pd_next;

   // asserted pins after polarity and enable
   logic [4:0] active;
   logic [4:0] rising;
   logic any_active;
   logic any_edge;
   logic others_active;
   logic wr_access;
   logic clear_ok;
   logic ack_event;

   // decode helper: true when the word address matches
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a[11:2] == r[11:2]);
   endfunction

   // decode helper: true for any of the four register words
   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, KWI_STATUS_CONTROL_ADDR) |
         hit(a, KWI_PIN_ENABLE_ADDR) |
         hit(a, KWI_PIN_POLARITY_ADDR) |
         hit(a, KWI_BREAK_FLAG_CONTROL_ADDR);
   endfunction

   // ------------------------------------------------------------------
   // detection terms
   // ------------------------------------------------------------------
   always_comb begin
      active = enable_reg & ~(sif.level ^ polarity_reg);
      rising = active & ~prev_reg;
      any_active = |active;
      any_edge = |rising;
      // a fresh edge only counts if no other enabled pin was already held
      others_active = |(prev_reg & active & ~rising);
   end

   // ------------------------------------------------------------------
   // bus strobes; the slave answers in the first access cycle
   // ------------------------------------------------------------------
   assign wr_access = psel & penable & pwrite & pready_reg;
   // break blocks status clears unless software allowed them
   assign clear_ok = ~break_active | allow_reg;
   assign ack_event = (wr_access & hit(paddr, KWI_STATUS_CONTROL_ADDR) &
      pwdata[KWI_REQUEST_ACK_BIT]) | vector_fetch;

   // ------------------------------------------------------------------
   // next-state for registers, latch and outputs
   // ------------------------------------------------------------------
   always_comb begin
      enable_next = enable_reg;
      polarity_next = polarity_reg;
      mask_next = mask_reg;
      sense_next = sense_reg;
      allow_next = allow_reg;
      latch_next = latch_reg;
      ack_pend_next = ack_pend_reg;
      prev_next = active;

      // software writes to control bits
      if (wr_access) begin
         if (hit(paddr, KWI_STATUS_CONTROL_ADDR)) begin
            mask_next = pwdata[KWI_REQUEST_MASK_BIT];
            sense_next = pwdata[KWI_SENSE_SELECT_BIT];
         end else if (hit(paddr, KWI_PIN_ENABLE_ADDR)) begin
            enable_next = pwdata[4:0];
         end else if (hit(paddr, KWI_PIN_POLARITY_ADDR)) begin
            polarity_next = pwdata[4:0];
         end else if (hit(paddr, KWI_BREAK_FLAG_CONTROL_ADDR)) begin
            allow_next = pwdata[KWI_BREAK_CLEAR_ALLOW_BIT];
         end
      end

      // acknowledge handling, gated by the break protection
      if (ack_event && clear_ok) begin
         if (sense_reg) begin
            ack_pend_next = 1'b1;
         end else begin
            latch_next = 1'b0;
         end
      end
      // edge-and-level: clear once acknowledged and all enabled inputs idle
      if (sense_reg && ack_pend_next && !any_active && clear_ok) begin
         latch_next = 1'b0;
         ack_pend_next = 1'b0;
      end
      if (!sense_reg) begin
         ack_pend_next = 1'b0;
      end

      // set wins over clear; an edge after acknowledge latches again
      if (any_edge && !others_active) begin
         latch_next = 1'b1;
         ack_pend_next = 1'b0;
      end else if (sense_reg && any_active && !ack_pend_next) begin
         latch_next = 1'b1;
      end
      // a held acknowledge survives a blocked break and completes later
      if (!clear_ok) begin
         latch_next = latch_reg | (any_edge & ~others_active) |
            (sense_reg & any_active);
      end

      // latch state is settled here; bus and pins follow below
   end

   // ------------------------------------------------------------------
   // bus response; a reply stands for the single access cycle only
   // ------------------------------------------------------------------
   always_comb begin
      // zero by default so no stale word lingers after an access
      prdata_next = KWI_ZERO_WORD;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      // every setup cycle is answered; the slave never stretches it
      if (psel && !penable) begin
         pready_next = 1'b1;
         // unmapped words answer with an error and drop any write
         pslverr_next = ~mapped(paddr);
         // reads of unmapped words leave the data at zero
         if (!pwrite) begin
            if (hit(paddr, KWI_STATUS_CONTROL_ADDR)) begin
               prdata_next[KWI_PENDING_FLAG_BIT] = latch_reg;
               prdata_next[KWI_REQUEST_MASK_BIT] = mask_reg;
               prdata_next[KWI_SENSE_SELECT_BIT] = sense_reg;
               // the acknowledge bit holds no state, so it reads 0
               prdata_next[KWI_REQUEST_ACK_BIT] = 1'b0;
            end else if (hit(paddr, KWI_PIN_ENABLE_ADDR)) begin
               prdata_next[4:0] = enable_reg;
            end else if (hit(paddr, KWI_PIN_POLARITY_ADDR)) begin
               prdata_next[4:0] = polarity_reg;
            end else if (hit(paddr, KWI_BREAK_FLAG_CONTROL_ADDR)) begin
               prdata_next[KWI_BREAK_CLEAR_ALLOW_BIT] = allow_reg;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // request, wake and pin control follow the next register state
   // ------------------------------------------------------------------
   // wake reuses the request term so both always agree
   always_comb begin
      // the request honours the mask; the pending flag does not
      irq_next = latch_next & ~mask_next;
      // the same request wakes the core from wait or stop
      wake_next = latch_next & ~mask_next;
      // enabled pins become inputs with a pull toward their idle level
      dir_next = port_dir_out & ~enable_next;
      // pull-up and pull-down never sit on one pin together
      pu_next = enable_next & ~polarity_next;
      pd_next = enable_next & polarity_next;
   end

   // ------------------------------------------------------------------
   // control registers and latch; pclk keeps running in wait and stop
   // ------------------------------------------------------------------
   // the reset branch loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= KWI_ENABLE_RESET;
         polarity_reg <= KWI_POLARITY_RESET;
         mask_reg <= KWI_MASK_RESET;
         sense_reg <= KWI_SENSE_RESET;
         allow_reg <= KWI_BREAK_ALLOW_RESET;
         latch_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         prev_reg <= 5'h00;
      end else begin
         enable_reg <= enable_next;
         polarity_reg <= polarity_next;
         mask_reg <= mask_next;
         sense_reg <= sense_next;
         allow_reg <= allow_next;
         latch_reg <= latch_next;
         ack_pend_reg <= ack_pend_next;
         prev_reg <= prev_next;
      end
   end

   // ------------------------------------------------------------------
   // bus response registers
   // ------------------------------------------------------------------
   // pready and pslverr fall again one cycle after they rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= KWI_ZERO_WORD;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ------------------------------------------------------------------
   // request and pin control registers
   // ------------------------------------------------------------------
   // registered so the request and pull controls never glitch at a pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
         dir_reg <= 5'h00;
         pu_reg <= 5'h00;
         pd_reg <= 5'h00;
      end else begin
         irq_reg <= irq_next;
         wake_reg <= wake_next;
         dir_reg <= dir_next;
         pu_reg <= pu_next;
         pd_reg <= pd_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_request = irq_reg;
   assign wake_request = wake_reg;
   assign pin_dir_out = dir_reg;
   assign pull_up_en = pu_reg;
   assign pull_down_en = pd_reg;
endmodule

// file: logic/kwi_pkg.sv
// package: register map, field positions and reset values of the key block
package kwi_pkg;
   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int KWI_PINS = 5;
   localparam int KWI_AW = 12;
   // ------------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------------
   localparam logic [11:0] KWI_STATUS_CONTROL_ADDR = 12'h000;
   localparam logic [11:0] KWI_PIN_ENABLE_ADDR = 12'h004;
   localparam logic [11:0] KWI_PIN_POLARITY_ADDR = 12'h008;
   localparam logic [11:0] KWI_BREAK_FLAG_CONTROL_ADDR = 12'h00C;
   // ------------------------------------------------------------------
   // status/control and break flag control field positions
   // ------------------------------------------------------------------
   localparam int KWI_SENSE_SELECT_BIT = 0;
   localparam int KWI_REQUEST_MASK_BIT = 1;
   localparam int KWI_REQUEST_ACK_BIT = 2;
   localparam int KWI_PENDING_FLAG_BIT = 3;
   localparam int KWI_BREAK_CLEAR_ALLOW_BIT = 0;
   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [4:0] KWI_ENABLE_RESET = 5'h00;
   localparam logic [4:0] KWI_POLARITY_RESET = 5'h00;
   localparam logic KWI_MASK_RESET = 1'b0;
   localparam logic KWI_SENSE_RESET = 1'b0;
   localparam logic KWI_BREAK_ALLOW_RESET = 1'b0;
   localparam logic [31:0] KWI_ZERO_WORD = 32'h0000_0000;
endpackage

// file: logic/kwi_sync_if.sv
// interface: raw key pins in, synchronised levels out
`timescale 1ns/10ps
interface kwi_sync_if;
   logic [4:0] raw;
   logic [4:0] level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface

// file: logic/kwi_sync.sv
// module: three-stage synchroniser for the key input pins
`timescale 1ns/10ps
module kwi_sync (
   input wire logic pclk,
   input wire logic presetn,
   kwi_sync_if.sync port
);
   import kwi_pkg::*;
   logic [4:0] s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [4:0] s1_next, s2_next, s3_next, lvl_next;

   // ------------------------------------------------------------------
   // next values: a change counts once stages two and three agree
   // ------------------------------------------------------------------
   always_comb begin
      s1_next = port.raw;
      s2_next = s1_reg;
      s3_next = s2_reg;
      lvl_next = lvl_reg;
      for (int i = 0; i < KWI_PINS; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            lvl_next[i] = s3_reg[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // registers; stage one feeds stage two only
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 5'h00;
         s2_reg <= 5'h00;
         s3_reg <= 5'h00;
         lvl_reg <= 5'h00;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         lvl_reg <= lvl_next;
      end
   end

   assign port.level = lvl_reg;
endmodule

// file: tb/kwi_properties.sv
// checker: port-level properties of the keyboard wake block
`timescale 1ns/10ps
module kwi_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [kwi_pkg::KWI_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [kwi_pkg::KWI_PINS-1:0] port_dir_out,
   input wire logic vector_fetch,
   input wire logic break_active,
   input wire logic [kwi_pkg::KWI_PINS-1:0] pin_dir_out,
   input wire logic [kwi_pkg::KWI_PINS-1:0] pull_up_en,
   input wire logic [kwi_pkg::KWI_PINS-1:0] pull_down_en,
   input wire logic irq_request,
   input wire logic wake_request
);
   import kwi_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   wake_irq_a:
      assert property (wake_request == irq_request)
      else $error("wake request differs from interrupt request");
   pull_excl_a:
      assert property ((pull_up_en & pull_down_en) == 5'h00)
      else $error("pull-up and pull-down on together");
   dir_forced_a:
      assert property (((pull_up_en | pull_down_en) & pin_dir_out) == 5'h00)
      else $error("enabled pin left as output");
   dir_pass_a:
      assert property ((pin_dir_out & ~$past(port_dir_out)) == 5'h00)
      else $error("pin output without port direction");
   ready_setup_a:
      assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   err_ready_a:
      assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a:
      assert property (!pready |-> prdata == KWI_ZERO_WORD)
      else $error("read data not zero outside reads");
   ack_reads0_a:
      assert property (pready && !pwrite && paddr[11:2] == 10'h000
         |-> prdata[31:4] == 28'h0 && !prdata[2])
      else $error("status read shows ack or high bits");
   mask_blocks_a:
      assert property (psel && penable && pready && pwrite
         && paddr[11:2] == 10'h000 && pwdata[KWI_REQUEST_MASK_BIT]
         |=> !irq_request)
      else $error("request still high after mask write");
   reset_quiet_a:
      assert property ($rose(presetn) |-> !irq_request
         && pull_up_en == 5'h00 && pull_down_en == 5'h00)
      else $error("outputs active at reset release");
   // main scenarios reached
   irq_c: cover property ($rose(irq_request));
   err_c: cover property (pslverr);
   fetch_c: cover property (vector_fetch && irq_request);
   brk_c: cover property (break_active && irq_request);
endmodule
bind kwi_top kwi_properties u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_dir_out(port_dir_out), .vector_fetch(vector_fetch),
   .break_active(break_active), .pin_dir_out(pin_dir_out),
   .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
   .irq_request(irq_request), .wake_request(wake_request));

// file: tb/kwi_keys.sv
// model: key switches and pull devices that drive the key inputs
`timescale 1ns/10ps
module kwi_keys (
   input wire logic pclk,
   input wire logic [kwi_pkg::KWI_PINS-1:0] press,
   input wire logic [kwi_pkg::KWI_PINS-1:0] pull_up_en,
   input wire logic [kwi_pkg::KWI_PINS-1:0] pull_down_en,
   output logic [kwi_pkg::KWI_PINS-1:0] pin_level
);
   import kwi_pkg::*;
   logic float_bit = 1'b0;
   // an unpulled open line wanders, so never let it hold a stale level
   always_ff @(posedge pclk) begin
      float_bit <= ~float_bit;
   end
   // a pressed key shorts the line against its pull device
   always_comb begin
      for (int i = 0; i < KWI_PINS; i++) begin
         if (press[i]) begin
            pin_level[i] = pull_down_en[i];
         end else if (pull_up_en[i] | pull_down_en[i]) begin
            pin_level[i] = pull_up_en[i];
         end else begin
            pin_level[i] = float_bit ^ i[0];
         end
      end
   end
endmodule

// file: tb/kwi_top_tb.sv
// testbench: registers, edge, level and break behaviour of the key block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); \
   end end
module kwi_top_tb;
   import kwi_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, vector_fetch, break_active;
   logic pready, pslverr, irq_request, wake_request, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0] key_wake_input, port_dir_out, pin_dir_out, press;
   logic [4:0] pull_up_en, pull_down_en;
   int mismatches, num_checks;
   kwi_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_wake_input(key_wake_input), .port_dir_out(port_dir_out),
      .vector_fetch(vector_fetch), .break_active(break_active),
      .pin_dir_out(pin_dir_out), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .irq_request(irq_request),
      .wake_request(wake_request));
   kwi_keys u_keys (.pclk(pclk), .press(press), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .pin_level(key_wake_input));
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic rst();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // values read right after an edge are those sampled at that edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic waiti(input logic e);
      int n;
      n = 0;
      while (irq_request !== e && n < 30) begin
         @(posedge pclk);
         n++;
      end
      `CHK(irq_request, e)
      `CHK(wake_request, e)
      if (irq_request !== e) complete_run();
   endtask
   // masked start-up, then a settle delay so false requests are acked
   task automatic init(input logic s, input logic [4:0] p, en);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, {30'h0, 1'b1, s});
      apb(1'b1, KWI_PIN_POLARITY_ADDR, {27'h0, p});
      apb(1'b1, KWI_PIN_ENABLE_ADDR, {27'h0, en});
      repeat (8) @(posedge pclk);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, {29'h0, 2'h3, s});
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, {31'h0, s});
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      rd(KWI_PIN_ENABLE_ADDR, 32'h0);
      rd(KWI_BREAK_FLAG_CONTROL_ADDR, 32'h0);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'hFFFF_FFFF);
      rd(KWI_STATUS_CONTROL_ADDR, 32'h3);
      apb(1'b1, KWI_PIN_POLARITY_ADDR, 32'hFFFF_FFF5);
      rd(KWI_PIN_POLARITY_ADDR, 32'h15);
      rd(12'h010, 32'h0);
      `CHK(last_err, 1'b1)
      rst();
      rd(KWI_PIN_POLARITY_ADDR, 32'h0);
      rd(KWI_STATUS_CONTROL_ADDR, 32'h0);
      $display("register test done");
   endtask
   task automatic t_edge();
      init(1'b0, 5'h05, 5'h1F);
      `CHK(pull_up_en, 5'h1A)
      `CHK(pull_down_en, 5'h05)
      `CHK(pin_dir_out, 5'h00)
      press <= 5'h02;
      waiti(1'b1);
      rd(KWI_STATUS_CONTROL_ADDR, 32'h8);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h4);
      waiti(1'b0);
      press <= 5'h0A;
      repeat (10) @(posedge pclk);
      `CHK(irq_request, 1'b0)
      press <= 5'h00;
      port_dir_out <= 5'h15;
      apb(1'b1, KWI_PIN_ENABLE_ADDR, 32'h0F);
      press <= 5'h10;
      repeat (10) @(posedge pclk);
      `CHK(irq_request, 1'b0)
      `CHK(pin_dir_out, 5'h10)
      press <= 5'h00;
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h2);
      press <= 5'h01;
      repeat (10) @(posedge pclk);
      `CHK(irq_request, 1'b0)
      rd(KWI_STATUS_CONTROL_ADDR, 32'hA);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h0);
      waiti(1'b1);
      vector_fetch <= 1'b1;
      @(posedge pclk);
      vector_fetch <= 1'b0;
      waiti(1'b0);
      press <= 5'h00;
      $display("edge test done");
   endtask
   task automatic t_level();
      init(1'b1, 5'h00, 5'h04);
      press <= 5'h04;
      waiti(1'b1);
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h5);
      repeat (10) @(posedge pclk);
      `CHK(irq_request, 1'b1)
      press <= 5'h00;
      waiti(1'b0);
      press <= 5'h04;
      waiti(1'b1);
      press <= 5'h00;
      repeat (10) @(posedge pclk);
      `CHK(irq_request, 1'b1)
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h5);
      waiti(1'b0);
      $display("level test done");
   endtask
   task automatic t_break();
      init(1'b0, 5'h00, 5'h01);
      press <= 5'h01;
      waiti(1'b1);
      press <= 5'h00;
      break_active <= 1'b1;
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h4);
      rd(KWI_STATUS_CONTROL_ADDR, 32'h8);
      break_active <= 1'b0;
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h4);
      waiti(1'b0);
      apb(1'b1, KWI_BREAK_FLAG_CONTROL_ADDR, 32'h1);
      press <= 5'h01;
      waiti(1'b1);
      press <= 5'h00;
      break_active <= 1'b1;
      apb(1'b1, KWI_STATUS_CONTROL_ADDR, 32'h4);
      waiti(1'b0);
      break_active <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK(irq_request, 1'b0)
      $display("break test done");
   endtask
   // ------------------------------------------------------------------
   // clock and main sequence
   // ------------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, vector_fetch, break_active} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      press = 5'h00;
      port_dir_out = 5'h1F;
      mismatches = 0;
      num_checks = 0;
      rst();
      t_regs();
      t_edge();
      t_level();
      t_break();
      complete_run();
   end
endmodule
